// ### dv/ivp_props.sv
`timescale 1ns/10ps
// ====================
// Port checker
module ivp_props (
  // Clock and reset
  input wire logic                      i_clk,
  input wire logic                      i_rst_b,
  // Register bus
  input wire logic                      i_wb_cyc,
  input wire logic                      i_wb_stb,
  input wire logic                      i_wb_we,
  input wire logic [ivp_pkg::WB_AW-1:0] i_wb_adr,
  input wire logic [3:0]                i_wb_sel,
  input wire logic [ivp_pkg::WB_DW-1:0] i_wb_dat,
  input wire logic [ivp_pkg::WB_DW-1:0] o_wb_dat,
  input wire logic                      o_wb_ack,
  // Core side
  input wire logic [ivp_pkg::PC_W-1:0]  i_pc,
  input wire logic                      i_global_ie,
  input wire logic                      i_irq_req,
  input wire logic [ivp_pkg::IDX_W-1:0] i_irq_index,
  input wire logic                      o_irq_take,
  input wire logic [ivp_pkg::PC_W-1:0]  o_irq_vector,
  input wire logic                      o_irq_masked,
  input wire logic [ivp_pkg::PC_W-1:0]  o_vec_start
);
  import ivp_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire gic_wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0] && (i_wb_adr == OFS_GEN_IRQ_CTRL);
  wire rd_ack = o_wb_ack && !i_wb_we;
  // ====================
  // Change sequence steps
  sequence s_arm;
    gic_wr && i_wb_dat[BIT_CHG_ENABLE];
  endsequence
  sequence s_arm_free;
    gic_wr && i_wb_dat[BIT_CHG_ENABLE] && !o_irq_masked && $stable(i_pc);
  endsequence
  sequence s_quiet;
    !i_wb_cyc && $stable(i_pc);
  endsequence
  // ====================
  // Assertions
  AST_ACK_PULSE: assert property ($rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack is not a single pulse one cycle after request");
  AST_READ_RSVD: assert property (rd_ack && i_wb_adr == OFS_GEN_IRQ_CTRL |-> o_wb_dat[31:2] == 30'h0)
    else $error("control register reserved bits not zero");
  AST_UNMAPPED: assert property (rd_ack && i_wb_adr[7:2] > OFS_RESET_ADDR[7:2] |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  AST_TAKE_IE: assert property (o_irq_take |-> i_global_ie && i_irq_req)
    else $error("interrupt taken without global enable");
  AST_MASK_MIRROR: assert property (i_irq_req && i_global_ie |=> o_irq_masked == !$past(o_irq_take))
    else $error("masked flag disagrees with refused interrupt");
  AST_ARM_BLOCKS: assert property (s_arm |=> (!o_irq_take) [*4])
    else $error("interrupt taken inside change window");
  AST_BLOCK_RELEASE: assert property (s_arm_free ##1 s_quiet [*5] |-> o_irq_take == (i_irq_req && i_global_ie))
    else $error("blocking not released after four cycles");
  AST_VEC_FORMULA: assert property (1'h1 |=> o_irq_vector == 12'(o_vec_start - 12'h001 + 12'($past(i_irq_index))))
    else $error("vector address is not table address plus start");
  AST_SEL_IGNORED: assert property (gic_wr && !i_wb_dat[0] && o_irq_take |=> ##1 o_vec_start == $past(o_vec_start, 2))
    else $error("select changed without change enable");
endmodule : ivp_props

// ### dv/ivp_vector_placement_test.sv
`timescale 1ns/10ps
module ivp_vector_placement_test;
  import ivp_pkg::*;
  // ====================
  // Signals
  logic             clk, rst_b, cyc, stb, we, req, gie, ack, take, masked;
  logic [WB_AW-1:0] adr;
  logic [3:0]       sel;
  logic [WB_DW-1:0] wdat, rdat, q;
  logic [PC_W-1:0]  pc, vec, vstart, raddr;
  logic [IDX_W-1:0] idx;
  int               bad_count = 0;
  int               n_tests = 0;
  int               cycles = 0;

  ivp_vector_placement uut (
    .i_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pc(pc), .i_global_ie(gie),
    .i_irq_req(req), .i_irq_index(idx), .o_irq_take(take), .o_irq_vector(vec), .o_irq_masked(masked),
    .o_vec_start(vstart), .o_reset_addr(raddr));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ====================
  // Helpers
  task ck(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : ck

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20) bad_count++;
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask : wb

  task mv(input logic s);
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h1);
    wb(1'h1, OFS_GEN_IRQ_CTRL, {30'h0, s, 1'h0});
    tick(1);
  endtask : mv

  task wrap_up;
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ====================
  // Scenarios
  task s_reset;
    wb(1'h0, OFS_GEN_IRQ_CTRL, 32'h0);
    ck(q, 32'h0);
    ck(vstart, 12'h001);
    wb(1'h1, OFS_VEC_START, 32'hfff);
    wb(1'h0, OFS_VEC_START, 32'h0);
    ck(q, 32'h001);
    wb(1'h1, 8'h40, 32'hff);
    wb(1'h0, 8'h40, 32'h0);
    ck(q, 32'h0);
    wb(1'h0, OFS_FUSE_CFG, 32'h0);
    ck(q, 32'h19);
  endtask : s_reset

  task s_move;
    req <= 1'h1;
    gie <= 1'h1;
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h1);
    ck(take, 1'h0);
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h2);
    ck(take, 1'h0);
    tick(1);
    ck(take, 1'h1);
    wb(1'h0, OFS_GEN_IRQ_CTRL, 32'h0);
    ck(q, 32'h2);
    ck(vstart, 12'hc01);
    ck(raddr, 12'h000);
    ck(vec, 12'hc01);
    idx <= 5'h12;
    tick(2);
    ck(vec, 12'hc12);
  endtask : s_move

  task s_window;
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h0);
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h1, 4'he);
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h0);
    tick(1);
    ck(vstart, 12'hc01);
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h1);
    tick(3);
    ck(take, 1'h0);
    tick(1);
    ck(take, 1'h1);
    wb(1'h0, OFS_GEN_IRQ_CTRL, 32'h0);
    ck(q, 32'h2);
    wb(1'h1, OFS_GEN_IRQ_CTRL, 32'h0);
    wb(1'h0, OFS_GEN_IRQ_CTRL, 32'h0);
    ck(q, 32'h2);
  endtask : s_window

  task s_fuse;
    mv(1'h0);
    wb(1'h1, OFS_FUSE_CFG, 32'h18);
    tick(1);
    ck(raddr, 12'hc00);
    ck(vstart, 12'h001);
    ck(vec, 12'h012);
    mv(1'h1);
    ck(raddr, 12'hc00);
    ck(vec, 12'hc12);
  endtask : s_fuse

  task s_lock;
    wb(1'h1, OFS_FUSE_CFG, 32'h10);
    pc <= 12'h100;
    tick(2);
    ck(take, 1'h0);
    ck(masked, 1'h1);
    wb(1'h0, OFS_STATUS, 32'h0);
    ck(q, 32'ha);
    pc <= 12'hc20;
    tick(2);
    ck(take, 1'h1);
    wb(1'h1, OFS_FUSE_CFG, 32'h08);
    mv(1'h0);
    ck(take, 1'h0);
    pc <= 12'h100;
    tick(2);
    ck(take, 1'h1);
    gie <= 1'h0;
    tick(2);
    ck(take, 1'h0);
  endtask : s_lock

  // ====================
  // Main sequence and timeout
  initial begin
    rst_b = 1'h0;
    cyc   = 1'h0;
    stb   = 1'h0;
    we    = 1'h0;
    adr   = 8'h00;
    sel   = 4'h0;
    wdat  = 32'h0;
    pc    = 12'h100;
    gie   = 1'h0;
    req   = 1'h0;
    idx   = 5'h01;
    tick(4);
    rst_b <= 1'h1;
    tick(1);
    s_reset();
    s_move();
    s_window();
    s_fuse();
    s_lock();
    wrap_up();
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
endmodule : ivp_vector_placement_test

bind ivp_vector_placement ivp_props u_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_pc(i_pc), .i_global_ie(i_global_ie), .i_irq_req(i_irq_req), .i_irq_index(i_irq_index),
  .o_irq_take(o_irq_take), .o_irq_vector(o_irq_vector), .o_irq_masked(o_irq_masked), .o_vec_start(o_vec_start));

// ### src/ivp_change_seq.sv
`timescale 1ns/10ps
module ivp_change_seq (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Control side
  ivp_seq_if.seq    seq
);
  import ivp_pkg::*;

  ivp_state_t         state;
  ivp_state_t         next_state;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  logic               next_sel;
  logic               next_ce;
  logic               vsel;
  logic               ce;

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_sel   = vsel;
    next_ce    = ce;
    case (state)
      IVP_IDLE: begin
        if (seq.wr && seq.wr_chg_enable) begin
          next_state = IVP_ARMED;
          next_cnt   = CHG_WINDOW_CYC;
          next_ce    = 1'b1;
        end
      end
      IVP_ARMED: begin
        if (seq.wr && !seq.wr_chg_enable) begin
          next_sel   = seq.wr_vec_select;
          next_ce    = 1'b0;
          next_state = IVP_HOLD;
          next_cnt   = INSN_HOLD_CYC;
        end else if (seq.wr && seq.wr_chg_enable) begin
          next_cnt   = CHG_WINDOW_CYC;
        end else if (cnt == 3'h1) begin
          next_ce    = 1'b0;
          next_state = IVP_IDLE;
        end else begin
          next_cnt   = cnt - 3'h1;
        end
      end
      IVP_HOLD: begin
        if (cnt == 3'h1) begin
          next_state = IVP_IDLE;
        end else begin
          next_cnt   = cnt - 3'h1;
        end
      end
      default: begin
        next_state = IVP_IDLE;
        next_ce    = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // State registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= IVP_IDLE;
      cnt   <= '0;
      vsel  <= RST_VEC_SELECT;
      ce    <= RST_CHG_ENABLE;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      vsel  <= next_sel;
      ce    <= next_ce;
    end
  end

  assign seq.vec_select = vsel;
  assign seq.chg_enable = ce;
  assign seq.seq_block  = (state != IVP_IDLE);

endmodule : ivp_change_seq

// ### src/ivp_pkg.sv
package ivp_pkg;

  // ==========================================================
  // Bus, address, index and counter widths
  localparam int unsigned WB_AW  = 8;
  localparam int unsigned WB_DW  = 32;
  localparam int unsigned PC_W   = 12;
  localparam int unsigned IDX_W  = 5;
  localparam int unsigned CNT_W  = 3;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [WB_AW-1:0] OFS_GEN_IRQ_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] OFS_FUSE_CFG     = 8'h04;
  localparam logic [WB_AW-1:0] OFS_STATUS       = 8'h08;
  localparam logic [WB_AW-1:0] OFS_VEC_START    = 8'h0c;
  localparam logic [WB_AW-1:0] OFS_RESET_ADDR   = 8'h10;

  // ==========================================================
  // General interrupt control fields
  localparam int unsigned BIT_VEC_SELECT = 1;
  localparam int unsigned BIT_CHG_ENABLE = 0;
  localparam logic        RST_VEC_SELECT = 1'b0;
  localparam logic        RST_CHG_ENABLE = 1'b0;

  // ==========================================================
  // Fuse and lock configuration fields (0 means programmed)
  localparam int unsigned BIT_BOOT_RESET = 0;
  localparam int unsigned BIT_BOOT_SIZE  = 1;
  localparam int unsigned BIT_APP_LOCK   = 3;
  localparam int unsigned BIT_BOOT_LOCK  = 4;
  localparam logic [4:0]  RST_FUSE_CFG   = 5'h19;

  // ==========================================================
  // Status fields
  localparam int unsigned BIT_ST_SEQ_BLOCK  = 0;
  localparam int unsigned BIT_ST_LOCK_MASK  = 1;
  localparam int unsigned BIT_ST_IN_BOOT    = 2;
  localparam int unsigned BIT_ST_IRQ_MASKED = 3;

  // ==========================================================
  // Boot section start word addresses by boot size code
  localparam logic [PC_W-1:0] BOOT_START_2K   = 12'hc00;
  localparam logic [PC_W-1:0] BOOT_START_1K   = 12'he00;
  localparam logic [PC_W-1:0] BOOT_START_512  = 12'hf00;
  localparam logic [PC_W-1:0] BOOT_START_256  = 12'hf80;
  localparam logic [PC_W-1:0] APP_START       = 12'h000;

  // ==========================================================
  // Timing counts in clock cycles
  localparam logic [CNT_W-1:0] CHG_WINDOW_CYC = 3'h4;
  localparam logic [CNT_W-1:0] INSN_HOLD_CYC  = 3'h1;

  // ==========================================================
  // Change sequencer states, Gray along idle, armed, hold
  typedef enum logic [1:0] {
    IVP_IDLE  = 2'b00,
    IVP_ARMED = 2'b01,
    IVP_HOLD  = 2'b11
  } ivp_state_t;

endpackage : ivp_pkg

// ### src/ivp_seq_if.sv
`timescale 1ns/10ps
interface ivp_seq_if;
  logic wr;
  logic wr_chg_enable;
  logic wr_vec_select;
  logic vec_select;
  logic chg_enable;
  logic seq_block;

  modport ctrl (
    output wr,
    output wr_chg_enable,
    output wr_vec_select,
    input  vec_select,
    input  chg_enable,
    input  seq_block
  );

  modport seq (
    input  wr,
    input  wr_chg_enable,
    input  wr_vec_select,
    output vec_select,
    output chg_enable,
    output seq_block
  );
endinterface : ivp_seq_if

// ### src/ivp_vector_placement.sv
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module ivp_vector_placement (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  // Wishbone slave
  input  wire logic                        i_wb_cyc,
  input  wire logic                        i_wb_stb,
  input  wire logic                        i_wb_we,
  input  wire logic [ivp_pkg::WB_AW-1:0]   i_wb_adr,
  input  wire logic [3:0]                  i_wb_sel,
  input  wire logic [ivp_pkg::WB_DW-1:0]   i_wb_dat,
  output logic      [ivp_pkg::WB_DW-1:0]   o_wb_dat,
  output logic                             o_wb_ack,
  // Core side
  input  wire logic [ivp_pkg::PC_W-1:0]    i_pc,
  input  wire logic                        i_global_ie,
  input  wire logic                        i_irq_req,
  input  wire logic [ivp_pkg::IDX_W-1:0]   i_irq_index,
  // Interrupt dispatch
  output logic                             o_irq_take,
  output logic      [ivp_pkg::PC_W-1:0]    o_irq_vector,
  output logic                             o_irq_masked,
  // Placement
  output logic      [ivp_pkg::PC_W-1:0]    o_vec_start,
  output logic      [ivp_pkg::PC_W-1:0]    o_reset_addr
);
  import ivp_pkg::*;

  // ==========================================================
  // Helper functions
  function automatic logic [PC_W-1:0] boot_start(input logic [1:0] code);
    logic [PC_W-1:0] s;
    case (code)
      2'h0:    s = BOOT_START_2K;
      2'h1:    s = BOOT_START_1K;
      2'h2:    s = BOOT_START_512;
      default: s = BOOT_START_256;
    endcase
    return s;
  endfunction : boot_start

  function automatic logic [PC_W-1:0] vec_addr(input logic sel,
                                               input logic [PC_W-1:0] start,
                                               input logic [IDX_W-1:0] idx);
    logic [PC_W-1:0] base;
    base = sel ? start : APP_START;
    return base + {{(PC_W-IDX_W){1'b0}}, idx};
  endfunction : vec_addr

  function automatic logic hit(input logic [WB_AW-1:0] adr, input logic [WB_AW-1:0] ofs);
    return adr[WB_AW-1:2] == ofs[WB_AW-1:2];
  endfunction : hit

  // ==========================================================
  // Declarations
  ivp_seq_if         sif ();
  logic              ack;
  logic [WB_DW-1:0]  rdata;
  logic [WB_DW-1:0]  next_rdata;
  logic [4:0]        fuse_cfg;
  logic [PC_W-1:0]   vec_start;
  logic [PC_W-1:0]   reset_addr;
  logic [PC_W-1:0]   irq_vector;
  logic              irq_masked;

  wire               req         = i_wb_cyc & i_wb_stb;
  wire               wr_take     = req & i_wb_we & ack & i_wb_sel[0];
  wire               hit_gic     = hit(i_wb_adr, OFS_GEN_IRQ_CTRL);
  wire               hit_fuse    = hit(i_wb_adr, OFS_FUSE_CFG);
  wire               hit_status  = hit(i_wb_adr, OFS_STATUS);
  wire               hit_vstart  = hit(i_wb_adr, OFS_VEC_START);
  wire               hit_rstaddr = hit(i_wb_adr, OFS_RESET_ADDR);

  // ==========================================================
  // Fuse and lock decode
  wire               boot_rst_prog  = ~fuse_cfg[BIT_BOOT_RESET];
  wire  [1:0]        boot_size_code = fuse_cfg[BIT_BOOT_SIZE +: 2];
  wire               app_lock_prog  = ~fuse_cfg[BIT_APP_LOCK];
  wire               boot_lock_prog = ~fuse_cfg[BIT_BOOT_LOCK];
  wire  [PC_W-1:0]   boot_base      = boot_start(boot_size_code);
  wire               in_boot        = (i_pc >= boot_base);
  wire               vsel           = sif.vec_select;

  // ==========================================================
  // Change sequencer
  // Select bit one, enable bit zero
  assign sif.wr            = wr_take & hit_gic;
  assign sif.wr_chg_enable = i_wb_dat[BIT_CHG_ENABLE];
  assign sif.wr_vec_select = i_wb_dat[BIT_VEC_SELECT];

  ivp_change_seq u_seq (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .seq     (sif.seq)
  );

  // ==========================================================
  // Vector placement
  // Application start when clear
  wire  [PC_W-1:0]   next_vec_start  = vec_addr(vsel, boot_base, 5'h01);
  wire  [PC_W-1:0]   next_irq_vector = vec_addr(vsel, boot_base, i_irq_index);
  wire  [PC_W-1:0]   next_reset_addr = boot_rst_prog ? boot_base : APP_START;

  // ==========================================================
  // Interrupt masking
  // Application masked under boot vectors
  wire               mask_app  = vsel & app_lock_prog & ~in_boot;
  wire               mask_boot = ~vsel & boot_lock_prog & in_boot;
  wire               lock_mask = mask_app | mask_boot;
  wire               next_irq_masked = sif.seq_block | lock_mask;

  assign o_irq_take = i_irq_req & i_global_ie & ~sif.seq_block & ~lock_mask;

  // ==========================================================
  // Read data
  always_comb begin
    next_rdata = '0;
    if (hit_gic) begin
      next_rdata[BIT_VEC_SELECT] = vsel;
      next_rdata[BIT_CHG_ENABLE] = sif.chg_enable;
    end else if (hit_fuse) begin
      next_rdata[4:0] = fuse_cfg;
    end else if (hit_status) begin
      next_rdata[BIT_ST_SEQ_BLOCK]  = sif.seq_block;
      next_rdata[BIT_ST_LOCK_MASK]  = lock_mask;
      next_rdata[BIT_ST_IN_BOOT]    = in_boot;
      next_rdata[BIT_ST_IRQ_MASKED] = next_irq_masked;
    end else if (hit_vstart) begin
      next_rdata[PC_W-1:0] = vec_start;
    end else if (hit_rstaddr) begin
      next_rdata[PC_W-1:0] = reset_addr;
    end
  end

  // ==========================================================
  // Bus answer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack   <= 1'b0;
      rdata <= '0;
    end else begin
      ack   <= req & ~ack;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Fuse configuration register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fuse_cfg <= RST_FUSE_CFG;
    end else if (wr_take && hit_fuse) begin
      fuse_cfg <= i_wb_dat[4:0];
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vec_start  <= 12'h001;
      reset_addr <= APP_START;
      irq_vector <= '0;
      irq_masked <= 1'b0;
    end else begin
      vec_start  <= next_vec_start;
      reset_addr <= next_reset_addr;
      irq_vector <= next_irq_vector;
      irq_masked <= next_irq_masked;
    end
  end

  assign o_wb_ack     = ack;
  assign o_wb_dat     = rdata;
  assign o_vec_start  = vec_start;
  assign o_reset_addr = reset_addr;
  assign o_irq_vector = irq_vector;
  assign o_irq_masked = irq_masked;

endmodule : ivp_vector_placement
